// ---- core/uhpm_pkg.sv ----
// Shared constants for the dual-channel UART host-pin logic.
// Assumes one 200 MHz clock at both ends and pins synchronous to it.
package uhpm_pkg;

	// ************************************************************
	// Channel register map, as seen on the parallel pins
	// ************************************************************
	localparam logic [2:0] REG_IER = 3'h1;
	localparam logic [2:0] REG_MCR = 3'h4;
	localparam logic [2:0] REG_MSR = 3'h6;
	localparam logic [2:0] REG_SPR = 3'h7;
	localparam int IER_MS_BIT = 3;
	localparam int MCR_RTS_BIT = 1;
	localparam int MCR_OUT2_BIT = 3;
	localparam int MSR_TERI_BIT = 2;
	localparam int MSR_RI_BIT = 6;
	localparam logic [7:0] IER_RST = 8'h00;
	localparam logic [7:0] MCR_RST = 8'h00;
	localparam logic [7:0] SPR_RST = 8'h00;

	// ************************************************************
	// Host controller software registers
	// ************************************************************
	localparam logic [7:0] H_CMD = 8'h00;
	localparam logic [7:0] H_RDATA = 8'h04;
	localparam logic [7:0] H_STAT = 8'h08;
	localparam logic [7:0] H_MASK = 8'h0C;
	localparam logic [7:0] H_CFG = 8'h10;
	localparam int CMD_CHAN_BIT = 3;
	localparam int CMD_READ_BIT = 4;
	localparam int CMD_DATA_LSB = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_IRQA_BIT = 2;
	localparam int STAT_IRQB_BIT = 3;
	localparam int CFG_BUS_BIT = 0;
	localparam int CFG_RST_BIT = 1;
	localparam logic [3:0] EVT_RST = 4'h0;
	localparam logic [1:0] CFG_RST = 2'h3;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 5;
	localparam int STROBE_NS = 20;
	localparam int STROBE_CYC_I = (STROBE_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam logic [2:0] STROBE_CYC = 3'(STROBE_CYC_I);

	typedef enum {
		UHPM_IDLE,
		UHPM_SETUP,
		UHPM_STROBE,
		UHPM_HOLD
	} uhpm_hst_t;

endpackage

// ---- core/uhpm_if.sv ----
// Pin bundle between the UART host-pin logic and its host CPU.
// Assumes the bench drives the ring inputs; the bus pull-up and the irq idle levels are modelled here.
`timescale 1ns/1ps
interface uhpm_if;
	// Mode and reset
	logic bus_sel;
	logic master_rst;
	// Select, address, strobes
	logic chip_sel_first;
	logic chip_sel_second;
	logic [2:0] reg_addr;
	logic rd_strobe_n;
	logic wr_strobe_n;
	// Two-way data
	logic [7:0] host_d;
	logic host_d_oe;
	logic [7:0] dev_d;
	logic dev_d_oe;
	logic [7:0] data_bus;
	// Interrupt pins
	logic chan_a_irq_out;
	logic chan_a_irq_oe;
	logic chan_b_irq_out;
	logic chan_b_irq_oe;
	logic irq_a_line;
	logic irq_b_line;
	// Modem side
	logic user_out2_a;
	logic user_out2_b;
	logic req_send_a;
	logic req_send_b;
	logic ring_ind_a;
	logic ring_ind_b;

	// Undriven bus idles high; a floating irq pin reads its inactive level
	assign data_bus = dev_d_oe ? dev_d : (host_d_oe ? host_d : 8'hFF);
	assign irq_a_line = chan_a_irq_oe ? chan_a_irq_out : ~bus_sel;
	assign irq_b_line = chan_b_irq_oe ? chan_b_irq_out : ~bus_sel;

	modport dev (
		input bus_sel, master_rst, chip_sel_first, chip_sel_second,
		input reg_addr, rd_strobe_n, wr_strobe_n, data_bus,
		input ring_ind_a, ring_ind_b,
		output dev_d, dev_d_oe, chan_a_irq_out, chan_a_irq_oe,
		output chan_b_irq_out, chan_b_irq_oe,
		output user_out2_a, user_out2_b, req_send_a, req_send_b
	);
	modport host (
		output bus_sel, master_rst, chip_sel_first, chip_sel_second,
		output reg_addr, rd_strobe_n, wr_strobe_n, host_d, host_d_oe,
		input data_bus, irq_a_line, irq_b_line
	);
endinterface

// ---- core/uhpm_dev.sv ----
// Device end: host-pin decode, per-channel control and interrupt pins.
// Assumes pins change in step with sys_clk and bus_sel is a board strap.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps

// ************************************************************
// One channel: enable, modem control, ring status
// ************************************************************
module uhpm_chan
	import uhpm_pkg::*;
(
	// Clock and resets
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic srst,
	// Register access
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	// Modem and interrupt
	input wire logic ring_ind,
	output logic irq,
	output logic [7:0] modem_ctrl_reg
);
	logic [7:0] ier_q, ier_d;
	logic [7:0] mcr_q, mcr_d;
	logic [7:0] spr_q, spr_d;
	logic teri_q, teri_d;
	logic ri_q, ri_d;
	logic ri_rise;

	assign ri_rise = ring_ind & ~ri_q;

	always_comb begin
		ier_d = ier_q;
		mcr_d = mcr_q;
		spr_d = spr_q;
		teri_d = teri_q;
		ri_d = ring_ind;
		if (wr_en) begin
			case (addr)
				REG_IER: ier_d = wdata;
				REG_MCR: mcr_d = wdata;
				REG_SPR: spr_d = wdata;
				default: ;
			endcase
		end
		// Status read clears the flag, but an edge in the same cycle stays
		if (rd_en && addr == REG_MSR) begin
			teri_d = 1'b0;
		end
		if (ri_rise) begin
			teri_d = 1'b1;
		end
		if (srst) begin
			ier_d = IER_RST;
			mcr_d = MCR_RST;
			spr_d = SPR_RST;
			teri_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ier_q <= IER_RST;
			mcr_q <= MCR_RST;
			spr_q <= SPR_RST;
			teri_q <= 1'b0;
			ri_q <= 1'b1;
		end else begin
			ier_q <= ier_d;
			mcr_q <= mcr_d;
			spr_q <= spr_d;
			teri_q <= teri_d;
			ri_q <= ri_d;
		end
	end

	always_comb begin
		rdata = 8'h00;
		case (addr)
			REG_IER: rdata = ier_q;
			REG_MCR: rdata = mcr_q;
			REG_MSR: begin
				rdata[MSR_TERI_BIT] = teri_q;
				rdata[MSR_RI_BIT] = ~ring_ind;
			end
			REG_SPR: rdata = spr_q;
			default: rdata = 8'h00;
		endcase
	end

	assign irq = teri_q & ier_q[IER_MS_BIT];
	assign modem_ctrl_reg = mcr_q;
endmodule

// ************************************************************
// Device top
// ************************************************************
// Contract
// - Separate-strobe mode: pin one A, two B.
// - Control bit3 set: drive irq, out2 low.
// - Control bit3 clear: irq floats, out2 high; shared-bus mode drives the irq pin whatever bit3 is.
// - Host uses irq or out2, not both.
// - Shared-bus mode: one shared open-drain low irq.
// - Shared-bus mode: second irq pin unused.
// - Separate-strobe mode: low read strobe reads.
// - Separate-strobe mode: low write strobe writes.
// - Shared-bus mode: direction high reads, low writes.
// - Separate-strobe mode: reset pin active high.
// - Shared-bus mode: reset pin active low.
// - Ring rising edge raises enabled channel interrupt.
// - Control bit1 drives request-to-send low.
// - Request-to-send high after any reset.
// - Shared-bus mode: first select covers both channels.
// - Shared-bus mode: second select picks channel.
module uhpm_dev
	import uhpm_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Pins
	uhpm_if.dev pins,
	// User-side status
	output logic mode_sep_strobe,
	output logic dev_in_reset
);
	logic strap_done_q, strap_done_d;
	logic mode_q, mode_d;
	logic wr_act_q, wr_act_d;
	logic rd_act_q, rd_act_d;
	logic [7:0] rd_data_q, rd_data_d;
	logic rd_oe_q, rd_oe_d;
	logic srst;
	logic sel_a, sel_b;
	logic rd_lvl, wr_lvl;
	logic rd_act, wr_act;
	logic wr_pulse, rd_pulse;
	logic [7:0] rdata_a, rdata_b;
	logic [7:0] mcr_a, mcr_b;
	logic irq_a, irq_b;

	// ************************************************************
	// Strap capture and pin reset
	// ************************************************************
	// Caught once after release so the reset polarity cannot flip later
	always_comb begin
		strap_done_d = 1'b1;
		mode_d = mode_q;
		if (!strap_done_q) begin
			mode_d = pins.bus_sel;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_done_q <= 1'b0;
			mode_q <= 1'b1;
		end else begin
			strap_done_q <= strap_done_d;
			mode_q <= mode_d;
		end
	end

	always_comb begin
		if (!strap_done_q) begin
			srst = 1'b1;
		end else if (mode_q) begin
			srst = pins.master_rst;
		end else begin
			srst = ~pins.master_rst;
		end
	end

	// ************************************************************
	// Access decode
	// ************************************************************
	always_comb begin
		if (mode_q) begin
			sel_a = ~pins.chip_sel_first;
			sel_b = ~pins.chip_sel_second & pins.chip_sel_first;
			rd_lvl = ~pins.rd_strobe_n;
			wr_lvl = ~pins.wr_strobe_n & pins.rd_strobe_n;
		end else begin
			sel_a = ~pins.chip_sel_first & ~pins.chip_sel_second;
			sel_b = ~pins.chip_sel_first & pins.chip_sel_second;
			rd_lvl = pins.wr_strobe_n;
			wr_lvl = ~pins.wr_strobe_n;
		end
	end

	assign rd_act = (sel_a | sel_b) & rd_lvl & ~srst;
	assign wr_act = (sel_a | sel_b) & wr_lvl & ~srst;
	// One register update per strobe, however long it is held
	assign wr_pulse = wr_act & ~wr_act_q;
	assign rd_pulse = rd_act & ~rd_act_q;

	always_comb begin
		wr_act_d = wr_act;
		rd_act_d = rd_act;
		rd_oe_d = rd_act;
		rd_data_d = rd_data_q;
		if (rd_pulse) begin
			rd_data_d = sel_a ? rdata_a : rdata_b;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_act_q <= 1'b0;
			rd_act_q <= 1'b0;
			rd_oe_q <= 1'b0;
			rd_data_q <= 8'h00;
		end else begin
			wr_act_q <= wr_act_d;
			rd_act_q <= rd_act_d;
			rd_oe_q <= rd_oe_d;
			rd_data_q <= rd_data_d;
		end
	end

	// ************************************************************
	// Channels
	// ************************************************************
	uhpm_chan u_chan_a (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.srst(srst),
		.wr_en(wr_pulse & sel_a),
		.rd_en(rd_pulse & sel_a),
		.addr(pins.reg_addr),
		.wdata(pins.data_bus),
		.rdata(rdata_a),
		.ring_ind(pins.ring_ind_a),
		.irq(irq_a),
		.modem_ctrl_reg(mcr_a)
	);

	uhpm_chan u_chan_b (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.srst(srst),
		.wr_en(wr_pulse & sel_b),
		.rd_en(rd_pulse & sel_b),
		.addr(pins.reg_addr),
		.wdata(pins.data_bus),
		.rdata(rdata_b),
		.ring_ind(pins.ring_ind_b),
		.irq(irq_b),
		.modem_ctrl_reg(mcr_b)
	);

	// ************************************************************
	// Pin outputs
	// ************************************************************
	assign pins.dev_d = rd_data_q;
	assign pins.dev_d_oe = rd_oe_q;

	// In separate-strobe mode bit3 governs both pins, so out2 and irq cannot be used together; shared-bus irq ignores it
	assign pins.user_out2_a = ~mcr_a[MCR_OUT2_BIT];
	assign pins.user_out2_b = ~mcr_b[MCR_OUT2_BIT];
	assign pins.req_send_a = ~mcr_a[MCR_RTS_BIT];
	assign pins.req_send_b = ~mcr_b[MCR_RTS_BIT];

	always_comb begin
		if (mode_q) begin
			pins.chan_a_irq_out = irq_a;
			pins.chan_a_irq_oe = mcr_a[MCR_OUT2_BIT];
			pins.chan_b_irq_out = irq_b;
			pins.chan_b_irq_oe = mcr_b[MCR_OUT2_BIT];
		end else begin
			// Open drain: only ever pulls low or lets go
			pins.chan_a_irq_out = 1'b0;
			pins.chan_a_irq_oe = irq_a | irq_b;
			pins.chan_b_irq_out = 1'b0;
			pins.chan_b_irq_oe = 1'b0;
		end
	end

	assign mode_sep_strobe = mode_q;
	assign dev_in_reset = srst;
endmodule

// ---- core/uhpm_host.sv ----
// Host end: runs single register accesses on the pins for software.
// Assumes the plain software port and a device clocked by sys_clk.
`timescale 1ns/1ps
module uhpm_host
	import uhpm_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Software port
	input wire logic [7:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	output logic irq,
	// Pins
	uhpm_if.host pins
);
	uhpm_hst_t st_q, st_d;
	logic [2:0] cnt_q, cnt_d;
	logic [15:0] cmd_q, cmd_d;
	logic [7:0] rbyte_q, rbyte_d;
	logic [3:0] evt_q, evt_d;
	logic [3:0] mask_q, mask_d;
	logic [1:0] cfg_q, cfg_d;
	logic [1:0] line_q, line_d;
	logic [31:0] rdata_q, rdata_d;
	logic busy, mode, chan, is_rd, in_xfer;
	logic [1:0] line_act;

	assign busy = (st_q != UHPM_IDLE);
	assign mode = cfg_q[CFG_BUS_BIT];
	assign chan = cmd_q[CMD_CHAN_BIT];
	assign is_rd = cmd_q[CMD_READ_BIT];
	assign in_xfer = busy;
	// Shared-bus mode irq is low active on the first pin only
	assign line_act[0] = mode ? pins.irq_a_line : ~pins.irq_a_line;
	assign line_act[1] = mode & pins.irq_b_line;

	// ************************************************************
	// Access sequencer and software registers
	// ************************************************************
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		cmd_d = cmd_q;
		rbyte_d = rbyte_q;
		evt_d = evt_q;
		mask_d = mask_q;
		cfg_d = cfg_q;
		line_d = line_act;
		rdata_d = 32'h0000_0000;
		case (st_q)
			UHPM_IDLE: begin
				if (sw_wr && sw_addr == H_CMD) begin
					cmd_d = sw_wdata[15:0];
					st_d = UHPM_SETUP;
				end
			end
			UHPM_SETUP: begin
				cnt_d = 3'h1;
				st_d = UHPM_STROBE;
			end
			UHPM_STROBE: begin
				cnt_d = cnt_q + 3'h1;
				if (cnt_q == STROBE_CYC) begin
					if (is_rd) begin
						rbyte_d = pins.data_bus;
					end
					st_d = UHPM_HOLD;
				end
			end
			UHPM_HOLD: begin
				st_d = UHPM_IDLE;
			end
			default: st_d = UHPM_IDLE;
		endcase
		if (sw_wr && sw_addr == H_STAT) begin
			evt_d = evt_q & ~sw_wdata[3:0];
		end
		if (sw_wr && sw_addr == H_MASK) begin
			mask_d = sw_wdata[3:0];
		end
		// Mode changes are only safe with the device held in reset
		if (sw_wr && sw_addr == H_CFG && !busy) begin
			cfg_d = sw_wdata[1:0];
		end
		// Events are set after the clear so a same-cycle event survives
		if (st_q == UHPM_HOLD) begin
			evt_d[STAT_DONE_BIT] = 1'b1;
		end
		if (line_act[0] && !line_q[0]) begin
			evt_d[STAT_IRQA_BIT] = 1'b1;
		end
		if (line_act[1] && !line_q[1]) begin
			evt_d[STAT_IRQB_BIT] = 1'b1;
		end
		if (sw_rd) begin
			case (sw_addr)
				H_CMD: rdata_d = {16'h0000, cmd_q};
				H_RDATA: rdata_d = {24'h00_0000, rbyte_q};
				H_STAT: rdata_d = {28'h000_0000, evt_q[3:1], busy};
				H_MASK: rdata_d = {28'h000_0000, mask_q};
				H_CFG: rdata_d = {30'h0000_0000, cfg_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= UHPM_IDLE;
			cnt_q <= 3'h0;
			cmd_q <= 16'h0000;
			rbyte_q <= 8'h00;
			evt_q <= EVT_RST;
			mask_q <= EVT_RST;
			cfg_q <= CFG_RST;
			line_q <= 2'h0;
			rdata_q <= 32'h0000_0000;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			cmd_q <= cmd_d;
			rbyte_q <= rbyte_d;
			evt_q <= evt_d;
			mask_q <= mask_d;
			cfg_q <= cfg_d;
			line_q <= line_d;
			rdata_q <= rdata_d;
		end
	end

	assign sw_rdata = rdata_q;
	assign irq = |(evt_q[3:1] & mask_q[3:1]);

	// ************************************************************
	// Pin drive
	// ************************************************************
	always_comb begin
		pins.bus_sel = mode;
		pins.master_rst = mode ? cfg_q[CFG_RST_BIT] : ~cfg_q[CFG_RST_BIT];
		pins.reg_addr = cmd_q[2:0];
		pins.host_d = cmd_q[CMD_DATA_LSB +: 8];
		pins.host_d_oe = in_xfer & ~is_rd;
		pins.rd_strobe_n = 1'b1;
		pins.wr_strobe_n = 1'b1;
		pins.chip_sel_first = 1'b1;
		pins.chip_sel_second = 1'b1;
		if (mode) begin
			pins.chip_sel_first = ~(in_xfer & ~chan);
			pins.chip_sel_second = ~(in_xfer & chan);
			if (st_q == UHPM_STROBE) begin
				pins.rd_strobe_n = ~is_rd;
				pins.wr_strobe_n = is_rd;
			end
		end else begin
			pins.chip_sel_second = chan;
			pins.wr_strobe_n = ~(in_xfer & ~is_rd);
			pins.chip_sel_first = ~(st_q == UHPM_STROBE);
		end
	end
endmodule

// ---- test/uhpm_sva.sv ----
// Checker on the pin bundle between the device and host ends.
// Assumes arst_n is the device reset and bus_sel is captured after it.
`timescale 1ns/1ps
module uhpm_sva (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Host-driven pins, plus the bench-driven ring input a
	input wire logic bus_sel,
	input wire logic master_rst,
	input wire logic chip_sel_first,
	input wire logic chip_sel_second,
	input wire logic rd_strobe_n,
	input wire logic wr_strobe_n,
	input wire logic host_d_oe,
	input wire logic ring_ind_a,
	// Device-driven pins
	input wire logic dev_d_oe,
	input wire logic chan_a_irq_out,
	input wire logic chan_a_irq_oe,
	input wire logic chan_b_irq_oe,
	input wire logic user_out2_a,
	input wire logic user_out2_b,
	input wire logic req_send_a,
	input wire logic req_send_b
);
	// ************************************************************
	// Own copy of the strap, so a late bus_sel change is not trusted
	// ************************************************************
	logic mode_q, first_q;
	logic rst_act, rd_lvl;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= 1'b1;
			first_q <= 1'b1;
		end else if (first_q) begin
			mode_q <= bus_sel;
			first_q <= 1'b0;
		end
	end
	assign rst_act = first_q | (mode_q ? master_rst : !master_rst);
	assign rd_lvl = mode_q ? (!rd_strobe_n && !(chip_sel_first &&
		chip_sel_second)) : (wr_strobe_n && !chip_sel_first);

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	out2_a_pair_a: assert property (mode_q && !first_q |->
		user_out2_a == !chan_a_irq_oe) else $error("out2 a vs irq a");
	out2_b_pair_a: assert property (mode_q && !first_q |->
		user_out2_b == !chan_b_irq_oe) else $error("out2 b vs irq b");
	b_pin_unused_a: assert property (!mode_q && !first_q |->
		!chan_b_irq_oe) else $error("second irq pin driven");
	drain_only_a: assert property (!mode_q && chan_a_irq_oe |->
		!chan_a_irq_out) else $error("shared irq driven high");
	rts_on_write_a: assert property ($fell(req_send_a) |->
		!$past(wr_strobe_n) || !$past(wr_strobe_n, 2))
		else $error("request-to-send fell without write");
	rts_reset_a: assert property (rst_act && !first_q |->
		##[1:2] (req_send_a && req_send_b))
		else $error("request-to-send low in reset");
	read_drive_a: assert property ((rd_lvl && !rst_act) [*2] |->
		dev_d_oe) else $error("read not driven");
	read_release_a: assert property ((!rd_lvl) [*2] |->
		!dev_d_oe) else $error("data driven without read");
	no_fight_a: assert property (!(dev_d_oe && host_d_oe))
		else $error("both ends drive data");

	cover property (mode_q && chan_a_irq_oe && $rose(ring_ind_a));
	cover property (!mode_q && rd_lvl && dev_d_oe);
	cover property (!first_q && rst_act && !mode_q);
endmodule

// ---- test/tb_top.sv ----
// Bench: host end and device end joined, driven through the software port.
// Assumes the device may be reset alone to capture a new bus style.
`timescale 1ns/1ps
module tb_top
	import uhpm_pkg::*;
;
	logic sys_clk, arst_n, dev_rst_n, sw_wr, sw_rd;
	logic [7:0] sw_addr;
	logic [31:0] sw_wdata, sw_rdata;
	logic irq, mode_sep_strobe, dev_in_reset;
	int n_mismatch = 0;
	int n_tests = 0;
	uhpm_if bus_if ();
	uhpm_dev uhpm_dev_i (.sys_clk(sys_clk), .arst_n(dev_rst_n),
		.pins(bus_if), .mode_sep_strobe(mode_sep_strobe),
		.dev_in_reset(dev_in_reset));
	uhpm_host uhpm_host_i (.sys_clk(sys_clk), .arst_n(arst_n),
		.sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
		.sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq), .pins(bus_if));
	uhpm_sva uhpm_sva_i (.sys_clk(sys_clk), .arst_n(dev_rst_n),
		.bus_sel(bus_if.bus_sel), .master_rst(bus_if.master_rst),
		.chip_sel_first(bus_if.chip_sel_first),
		.chip_sel_second(bus_if.chip_sel_second),
		.rd_strobe_n(bus_if.rd_strobe_n), .wr_strobe_n(bus_if.wr_strobe_n),
		.host_d_oe(bus_if.host_d_oe), .ring_ind_a(bus_if.ring_ind_a),
		.dev_d_oe(bus_if.dev_d_oe), .chan_a_irq_out(bus_if.chan_a_irq_out),
		.chan_a_irq_oe(bus_if.chan_a_irq_oe),
		.chan_b_irq_oe(bus_if.chan_b_irq_oe),
		.user_out2_a(bus_if.user_out2_a), .user_out2_b(bus_if.user_out2_b),
		.req_send_a(bus_if.req_send_a), .req_send_b(bus_if.req_send_b));

	always #(CLK_PERIOD_NS / 2.0) sys_clk = ~sys_clk;

	// ************************************************************
	// Access tasks
	// ************************************************************
	task automatic results;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		check(nm, {31'h0, e}, {31'h0, g});
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge sys_clk);
		sw_wr <= 1'b0;
	endtask
	task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge sys_clk);
		sw_rd <= 1'b0;
		#1 d = sw_rdata;
	endtask
	// Waits on done, not busy, so a late busy cannot fool the poll
	task automatic cmd(input logic ch, input logic [2:0] a,
		input logic rd, input logic [7:0] d);
		logic [31:0] s;
		sw_write(H_CMD, {16'h0000, d, 3'h0, rd, ch, a});
		s = 32'h0;
		for (int i = 0; i < 40 && s[STAT_DONE_BIT] !== 1'b1; i++)
			sw_read(H_STAT, s);
		chk1("access done", 1'b1, s[STAT_DONE_BIT]);
		sw_write(H_STAT, 32'h2);
	endtask
	task automatic rd_dev(input logic ch, input logic [2:0] a,
		input logic [7:0] e, input string nm);
		logic [31:0] v;
		cmd(ch, a, 1'b1, 8'h00);
		sw_read(H_RDATA, v);
		check(nm, {24'h0, e}, {24'h0, v[7:0]});
	endtask

	// ************************************************************
	// Sequence
	// ************************************************************
	initial begin
		sys_clk = 1'b0;
		arst_n = 1'b0;
		dev_rst_n = 1'b0;
		{sw_wr, sw_rd, sw_addr, sw_wdata} = '0;
		bus_if.ring_ind_a = 1'b1;
		bus_if.ring_ind_b = 1'b1;
		repeat (4) @(posedge sys_clk);
		arst_n <= 1'b1;
		dev_rst_n <= 1'b1;
		pause(2);
		chk1("rts a", 1'b1, bus_if.req_send_a);
		chk1("out2 a", 1'b1, bus_if.user_out2_a);
		chk1("irq a oe", 1'b0, bus_if.chan_a_irq_oe);
		sw_write(H_CFG, 32'h1);
		pause(3);
		chk1("in reset", 1'b0, dev_in_reset);
		chk1("sep mode", 1'b1, mode_sep_strobe);
		cmd(1'b0, REG_MCR, 1'b0, 8'h0A);
		chk1("rts a on", 1'b0, bus_if.req_send_a);
		chk1("rts b", 1'b1, bus_if.req_send_b);
		chk1("out2 a on", 1'b0, bus_if.user_out2_a);
		chk1("irq a oe on", 1'b1, bus_if.chan_a_irq_oe);
		cmd(1'b1, REG_SPR, 1'b0, 8'hA5);
		cmd(1'b0, REG_SPR, 1'b0, 8'h5A);
		rd_dev(1'b1, REG_SPR, 8'hA5, "spr b");
		rd_dev(1'b0, REG_SPR, 8'h5A, "spr a");
		cmd(1'b0, REG_IER, 1'b0, 8'h08);
		sw_write(H_MASK, 32'h4);
		bus_if.ring_ind_a <= 1'b0;
		pause(4);
		chk1("irq on ring fall", 1'b0, irq);
		bus_if.ring_ind_a <= 1'b1;
		pause(4);
		chk1("line a", 1'b1, bus_if.irq_a_line);
		chk1("host irq", 1'b1, irq);
		rd_dev(1'b0, REG_MSR, 8'h04, "msr a");
		sw_write(H_STAT, 32'hE);
		pause(2);
		chk1("irq cleared", 1'b0, irq);
		sw_write(H_CFG, 32'h3);
		pause(3);
		chk1("pin reset", 1'b1, dev_in_reset);
		chk1("rts a reset", 1'b1, bus_if.req_send_a);
		// New bus style only while the device end is held in reset
		@(posedge sys_clk);
		dev_rst_n <= 1'b0;
		sw_write(H_CFG, 32'h2);
		@(posedge sys_clk);
		dev_rst_n <= 1'b1;
		pause(3);
		chk1("shared mode", 1'b0, mode_sep_strobe);
		chk1("low reset", 1'b1, dev_in_reset);
		sw_write(H_CFG, 32'h0);
		pause(3);
		chk1("low reset off", 1'b0, dev_in_reset);
		cmd(1'b1, REG_SPR, 1'b0, 8'h3C);
		cmd(1'b0, REG_SPR, 1'b0, 8'hC3);
		rd_dev(1'b1, REG_SPR, 8'h3C, "shared spr b");
		rd_dev(1'b0, REG_SPR, 8'hC3, "shared spr a");
		cmd(1'b1, REG_MCR, 1'b0, 8'h08);
		chk1("irq b unused", 1'b0, bus_if.chan_b_irq_oe);
		chk1("out2 b on", 1'b0, bus_if.user_out2_b);
		cmd(1'b1, REG_IER, 1'b0, 8'h08);
		sw_write(H_STAT, 32'hE);
		bus_if.ring_ind_b <= 1'b0;
		pause(3);
		bus_if.ring_ind_b <= 1'b1;
		pause(4);
		chk1("shared line low", 1'b0, bus_if.irq_a_line);
		chk1("shared host irq", 1'b1, irq);
		sw_write(H_CFG, 32'h1);
		pause(3);
		chk1("strap held", 1'b0, mode_sep_strobe);
		results();
	end

	initial begin
		#100000;
		n_mismatch++;
		results();
	end
endmodule
